// >>> design/sct_cfg.svh
// What this block does
// - With the tone interrupt enabled, a newly detected programmed tone raises the interrupt.
// - With it enabled, a detected tone that ends or changes to another also raises it.
// - Each scan walks the tone table in order and reports the first entry that matches.
// - Every tone frequency used for detection comes from the host-loaded programming words.
// - Detection applies the host-loaded bandwidth and threshold settings.
// - Tones are 5-bit codes, the same in the transmit tone and tone status registers.
// - With the fifth bit clear, 0 is no tone, 14 is the repeat tone and the rest are reserved.
// - With the fifth bit set, low codes 0 to 15 map in order to the sixteen normal tone words.
// - A received repeat tone is reported as its own code, never as the previous tone.
// - Detection works on the band-pass filtered receive signal only.
// Purpose: Register offsets, table indices and tone codes of the tone decoder
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef SCT_CFG_SVH
`define SCT_CFG_SVH

`define SCT_ADDR_TX_TONE     8'hc3
`define SCT_ADDR_PROG        8'hc8
`define SCT_ADDR_STATUS      8'hcc
`define SCT_WORD_DETECT      5'h01
`define SCT_WORD_REPEAT      5'h02
`define SCT_WORD_FIRST       5'h03
`define SCT_WORD_LAST        5'h12
`define SCT_CODE_NONE        5'h00
`define SCT_CODE_REPEAT      5'h0e
`define SCT_CODE_NORMAL_BIT  4
`define SCT_DETECT_BW_MSB    15
`define SCT_DETECT_BW_LSB    8
`define SCT_DETECT_THR_MSB   7
`define SCT_DETECT_THR_LSB   0
`define SCT_DETECT_RESET     16'h0000

`endif

// >>> design/sct_pkg.sv
// Purpose: Types of the tone decoder
// Assumes: None
// Notes:   Constants live in sct_cfg.svh
package sct_pkg;
  typedef enum logic [1:0] {SCT_IDLE, SCT_SCAN, SCT_CHECK} sct_state_t;
endpackage : sct_pkg

// >>> design/sct_tone_mem.sv
// Purpose: Tone frequency word store
// Assumes: One write and one read port on the core clock
// Notes:   Read data come out of a register one cycle after the address
`timescale 1ns/1ps
module sct_tone_mem #(
  parameter int DW = 16,
  parameter int AW = 5
) (
  input  wire logic          i_core_clk, // Core clock
  input  wire logic          i_we,       // Write strobe
  input  wire logic [AW-1:0] i_waddr,    // Write word index
  input  wire logic [DW-1:0] i_wdata,    // Write data
  input  wire logic [AW-1:0] i_raddr,    // Read word index
  output logic      [DW-1:0] o_rdata     // Registered read data
);
  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge i_core_clk)
  begin
    if (i_we)
    begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    o_rdata <= mem_q[i_raddr];
  end
endmodule : sct_tone_mem

// >>> design/sct_tone_decoder.sv
// Purpose: Sequential-call tone decoder with tone status and interrupt
// Assumes: Frequency and level estimates come from the band-pass filter on this clock
// Notes:   Register port is the device's own control port, one access per cycle
`timescale 1ns/1ps
`include "sct_cfg.svh"
module sct_tone_decoder
  import sct_pkg::*;
#(
  parameter int FW = 16
) (
  input  wire logic          i_core_clk,     // Core clock, 40 MHz
  input  wire logic          i_sys_rst,      // Async reset, active high
  input  wire logic          i_reg_wr,       // Register write strobe
  input  wire logic          i_reg_rd,       // Register read strobe
  input  wire logic [7:0]    i_reg_addr,     // Register address
  input  wire logic [15:0]   i_reg_wdata,    // Register write data
  output logic      [15:0]   o_reg_rdata,    // Registered read data
  input  wire logic [4:0]    i_prog_sel,     // Programming word index
  input  wire logic          i_tone_irq_en,  // Tone interrupt enable
  input  wire logic          i_bpf_valid,    // Filtered estimate strobe
  input  wire logic [FW-1:0] i_bpf_freq,     // Filtered frequency estimate
  input  wire logic [15:0]   i_bpf_level,    // Filtered signal level
  output logic      [4:0]    o_tx_tone_code, // Transmit tone code
  output logic      [4:0]    o_tone_status,  // Current detected code
  output logic               o_tone_irq      // Tone start/end interrupt
);
  sct_state_t     st_q;
  logic [4:0]     idx_q;
  logic [FW-1:0]  freq_q;
  logic [15:0]    level_q;
  logic [15:0]    detect_q;
  logic [4:0]     status_q;
  logic           irq_q;
  logic [FW-1:0]  word;
  logic [FW-1:0]  diff;
  logic           hit;
  logic           last;
  logic [4:0]     hit_code;
  logic [4:0]     new_code;
  logic           upd;
  logic           prog_wr;
  logic           status_rd;

  assign prog_wr   = i_reg_wr && (i_reg_addr == `SCT_ADDR_PROG);
  assign status_rd = i_reg_rd && (i_reg_addr == `SCT_ADDR_STATUS);

  // Tone words all come from host loads
  sct_tone_mem #(.DW(FW), .AW(5)) u_mem (
    .i_core_clk (i_core_clk),
    .i_we       (prog_wr && (i_prog_sel != `SCT_WORD_DETECT)),
    .i_waddr    (i_prog_sel),
    .i_wdata    (i_reg_wdata[FW-1:0]),
    .i_raddr    (idx_q),
    .o_rdata    (word)
  );

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      detect_q <= `SCT_DETECT_RESET;
    end
    else if (prog_wr && (i_prog_sel == `SCT_WORD_DETECT))
    begin
      detect_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_tx_tone_code <= `SCT_CODE_NONE;
    end
    else if (i_reg_wr && (i_reg_addr == `SCT_ADDR_TX_TONE))
    begin
      o_tx_tone_code <= i_reg_wdata[4:0];
    end
  end

  // Match test on the sampled filtered estimate
  assign diff = (freq_q >= word) ? (freq_q - word) : (word - freq_q);
  assign hit  = (diff <= FW'(detect_q[`SCT_DETECT_BW_MSB:`SCT_DETECT_BW_LSB]))
             && (level_q[15:8] >= detect_q[`SCT_DETECT_THR_MSB:`SCT_DETECT_THR_LSB]);
  assign last = (idx_q == `SCT_WORD_LAST);
  // Repeat word reports its own code; normal words map in order
  assign hit_code = (idx_q == `SCT_WORD_REPEAT) ? `SCT_CODE_REPEAT
                  : {1'b1, 4'(idx_q - `SCT_WORD_FIRST)};
  assign new_code = hit ? hit_code : `SCT_CODE_NONE;
  assign upd      = (st_q == SCT_CHECK) && (hit || last);

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_q    <= SCT_IDLE;
      idx_q   <= `SCT_WORD_REPEAT;
      freq_q  <= '0;
      level_q <= 16'h0000;
    end
    else
    begin
      unique case (st_q)
        SCT_IDLE:
        begin
          if (i_bpf_valid)
          begin
            freq_q  <= i_bpf_freq;
            level_q <= i_bpf_level;
            idx_q   <= `SCT_WORD_REPEAT;
            st_q    <= SCT_SCAN;
          end
        end
        SCT_SCAN:
        begin
          st_q <= SCT_CHECK;
        end
        SCT_CHECK:
        begin
          // First match ends the scan
          if (hit || last)
          begin
            st_q <= SCT_IDLE;
          end
          else
          begin
            idx_q <= idx_q + 5'h01;
            st_q  <= SCT_SCAN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      status_q <= `SCT_CODE_NONE;
    end
    else if (upd && (new_code != status_q))
    begin
      status_q <= new_code;
    end
  end

  // Start, change and end all interrupt; set wins over read clear
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      irq_q <= 1'b0;
    end
    else if (upd && (new_code != status_q) && i_tone_irq_en)
    begin
      irq_q <= 1'b1;
    end
    else if (status_rd)
    begin
      irq_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_reg_rdata <= 16'h0000;
    end
    else if (status_rd)
    begin
      o_reg_rdata <= {11'h000, status_q};
    end
    else if (i_reg_rd)
    begin
      o_reg_rdata <= 16'h0000;
    end
  end

  assign o_tone_status = status_q;
  assign o_tone_irq    = irq_q;

  property p_irq_start;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (upd && hit && status_q == `SCT_CODE_NONE && i_tone_irq_en) |=> o_tone_irq;
  endproperty
  a_irq_start: assert property (p_irq_start) else $error("No irq at tone start");

  property p_irq_end;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (upd && status_q != `SCT_CODE_NONE && new_code != status_q && i_tone_irq_en)
      |=> (o_tone_irq && o_tone_status == $past(new_code));
  endproperty
  a_irq_end: assert property (p_irq_end) else $error("No irq at tone end");

  property p_first_match;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (st_q == SCT_CHECK && hit) |=> (st_q == SCT_IDLE && idx_q == $past(idx_q));
  endproperty
  a_first_match: assert property (p_first_match) else $error("Scan ran past a match");

  property p_table_range;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (st_q != SCT_IDLE) |-> (idx_q >= `SCT_WORD_REPEAT && idx_q <= `SCT_WORD_LAST);
  endproperty
  a_table_range: assert property (p_table_range) else $error("Scan outside tone words");

  property p_threshold;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (st_q == SCT_CHECK && level_q[15:8] < detect_q[7:0]) |-> !hit;
  endproperty
  a_threshold: assert property (p_threshold) else $error("Hit below threshold");

  property p_status_read;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    status_rd |=> (o_reg_rdata == {11'h000, $past(status_q)});
  endproperty
  a_status_read: assert property (p_status_read) else $error("Bad status read");

  property p_no_reserved;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    !status_q[4] |-> (status_q == `SCT_CODE_NONE || status_q == `SCT_CODE_REPEAT);
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("Reserved code reported");

  property p_normal_map;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (st_q == SCT_CHECK && hit && idx_q == `SCT_WORD_FIRST && status_q != 5'h10)
      |=> (status_q == 5'h10);
  endproperty
  a_normal_map: assert property (p_normal_map) else $error("Bad normal code");

  property p_repeat_own;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (st_q == SCT_CHECK && hit && idx_q == `SCT_WORD_REPEAT) |=> (status_q == 5'h0e);
  endproperty
  a_repeat_own: assert property (p_repeat_own) else $error("Repeat not reported");

  property p_sample;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (st_q == SCT_IDLE && i_bpf_valid) |=> (st_q == SCT_SCAN && freq_q == $past(i_bpf_freq));
  endproperty
  a_sample: assert property (p_sample) else $error("Estimate not sampled");

  property p_status_cause;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    $changed(status_q) |-> $past(upd);
  endproperty
  a_status_cause: assert property (p_status_cause) else $error("Status changed outside scan");

  c_start:  cover property (@(posedge i_core_clk) $rose(o_tone_irq) && status_q[4]);
  c_repeat: cover property (@(posedge i_core_clk) status_q == `SCT_CODE_REPEAT);
  c_end:    cover property (@(posedge i_core_clk)
                            $changed(status_q) && status_q == `SCT_CODE_NONE);
endmodule : sct_tone_decoder

// >>> test/sct_tone_src.sv
// Purpose: Filtered receive estimate source standing in for the band-pass stage
// Assumes: One estimate every 40 cycles, longer than a full table scan
// Notes:   Between strobes the estimates are not held
`timescale 1ns/1ps
module sct_tone_src (
  input  wire logic        i_core_clk, // Core clock
  input  wire logic        i_sys_rst,  // Async reset
  input  wire logic        i_on,       // Estimates flowing
  input  wire logic [15:0] i_freq,     // Tone frequency word
  input  wire logic [15:0] i_level,    // Tone level
  output logic             o_valid,    // Estimate strobe
  output logic      [15:0] o_freq,     // Frequency estimate
  output logic      [15:0] o_level     // Level estimate
);
  logic [5:0] cnt_q;
  // Only filtered voice-band estimates reach the decoder
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      cnt_q   <= '0;
      o_valid <= 1'b0;
      o_freq  <= 16'h0000;
      o_level <= 16'h0000;
    end
    else if (i_on && cnt_q == 6'd39)
    begin
      cnt_q   <= '0;
      o_valid <= 1'b1;
      o_freq  <= i_freq;
      o_level <= i_level;
    end
    else
    begin
      cnt_q   <= i_on ? cnt_q + 6'd1 : '0;
      o_valid <= 1'b0;
      o_freq  <= ~o_freq;
      o_level <= ~o_level;
    end
endmodule : sct_tone_src

// >>> test/sct_tone_decoder_tb.sv
// Purpose: Self-checking bench of the tone decoder
// Assumes: Host side driven by tasks, estimates by the source model
// Notes:   Tone words 0x1000 + n*0x100, repeat 0x0800, bandwidth 0x10
`timescale 1ns/1ps
module sct_tone_decoder_tb;
  logic        clk, rst, wr, rd, irq_en, src_on, valid, irq, aud;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, s_freq, s_level, freq, level;
  logic [4:0]  sel, txc, stat;
  logic [3:0]  dig;
  logic [4:0]  codes [4] = '{5'h0e, 5'h10, 5'h1f, 5'h00};
  int          err_total, compares;

  sct_tone_decoder i_sct_tone_decoder (.i_core_clk(clk), .i_sys_rst(rst), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_prog_sel(sel), .i_tone_irq_en(irq_en), .i_bpf_valid(valid), .i_bpf_freq(freq),
    .i_bpf_level(level), .o_tx_tone_code(txc), .o_tone_status(stat), .o_tone_irq(irq));
  sct_tone_src i_sct_tone_src (.i_core_clk(clk), .i_sys_rst(rst), .i_on(src_on),
    .i_freq(s_freq), .i_level(s_level), .o_valid(valid), .o_freq(freq), .o_level(level));

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
    cmp(g, e);
  endtask : chk_reg
  task automatic chk_code(input logic [4:0] g, input logic [4:0] e);
    cmp({11'h000, g}, {11'h000, e});
  endtask : chk_code
  task automatic chk_flag(input logic g, input logic e);
    cmp({15'h0000, g}, {15'h0000, e});
  endtask : chk_flag

  task automatic wr_reg(input logic [7:0] a, input logic [4:0] s, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    sel <= s;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_reg(rdata, e);
  endtask : rd_reg
  // Present tone c offset by off at level lv; expect code e
  task automatic tone(input logic [4:0] c, input logic [15:0] off, input logic [15:0] lv,
    input logic [4:0] e);
    @(posedge clk);
    s_freq <= (c == 5'h0e ? 16'h0800 : 16'h1000 + {4'h0, c[3:0], 8'h00}) + off;
    s_level <= lv;
    #1;
    for (int k = 0; k < 200 && stat !== e; k++)
    begin
      @(posedge clk);
      #1;
    end
    chk_code(stat, e);
    chk_flag(irq, irq_en);
    // Host audio gate follows the tone interrupts
    if (irq === 1'b1)
      aud = (stat !== 5'h00);
    if (irq_en)
      chk_flag(aud, e != 5'h00);
    rd_reg(8'hcc, {11'h000, e});
    chk_flag(irq, 1'b0);
  endtask : tone

  task automatic summarize;
    $display("mismatches %0d, comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    #(25 * 20000);
    err_total++;
    summarize();
  end

  initial
  begin
    {rst, wr, rd, irq_en, src_on} = 5'b10000;
    addr = 8'h00;
    aud = 1'b0;
    sel = 5'h00;
    wdata = 16'h0000;
    s_freq = 16'h0000;
    s_level = 16'h0000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_code(stat, 5'h00);
    chk_flag(irq, 1'b0);
    rd_reg(8'hcc, 16'h0000);
    foreach (codes[i])
    begin
      wr_reg(8'hc3, 5'h00, {11'h7ff, codes[i]});
      chk_code(txc, codes[i]);
    end
    rd_reg(8'hc3, 16'h0000);
    wr_reg(8'hcc, 5'h00, 16'h001f);
    rd_reg(8'hcc, 16'h0000);
    rd_reg(8'h55, 16'h0000);
    wr_reg(8'hc8, 5'h01, 16'h1020);
    wr_reg(8'hc8, 5'h02, 16'h0800);
    for (int n = 0; n < 16; n++)
      wr_reg(8'hc8, 5'(3 + n), 16'h1000 + 16'(n * 256));
    @(posedge clk);
    src_on <= 1'b1;
    irq_en <= 1'b1;
    for (int n = 0; n < 16; n++)
      tone(5'h10 + 5'(n), n[0] ? 16'h0010 : 16'hfff0, 16'h3000, 5'h10 + 5'(n));
    dig = 4'h0;
    for (int i = 0; i < 3; i++)
    begin
      tone(i == 1 ? 5'h0e : 5'h13, 16'h0000, 16'h3000, i == 1 ? 5'h0e : 5'h13);
      dig = (stat === 5'h0e) ? dig : stat[3:0];
      chk_code({1'b1, dig}, 5'h13);
    end
    tone(5'h0e, 16'h0000, 16'h2000, 5'h0e);
    tone(5'h0e, 16'h0000, 16'h1fff, 5'h00);
    tone(5'h15, 16'h0000, 16'h3000, 5'h15);
    tone(5'h15, 16'h0011, 16'h3000, 5'h00);
    wr_reg(8'hc8, 5'h04, 16'h1000);
    tone(5'h10, 16'h0000, 16'h3000, 5'h10);
    tone(5'h1a, 16'h0000, 16'h3000, 5'h1a);
    @(posedge clk);
    irq_en <= 1'b0;
    tone(5'h13, 16'h0000, 16'h3000, 5'h13);
    tone(5'h13, 16'h0000, 16'h0000, 5'h00);
    summarize();
  end
endmodule : sct_tone_decoder_tb
